//--- logic/gpti_core.sv
// gain select, count prescaler and threshold interrupt of a four-channel light sensor
// Overview of operation
// (RULE1) one gain setting from register 07h drives all four ADC channels alike
// (RULE2) gain bits 5:4 select 1x, 4x, 16x or 64x
// (RULE3) divider bits 2:0 right-shift each count by 0 to 6; 111 unused
// (RULE4) host writes zero to reserved gain register bits 7:6 and 3
// (RULE5) low and high thresholds are each 16 bits from two byte registers
// (RULE6) low threshold at 08h/09h, high threshold at 0Ah/0Bh, lower byte first
// (RULE7) interrupt when selected result is at or below low threshold
// (RULE8) interrupt when selected result is above high threshold
// (RULE9) all threshold bytes clear to zero at reset
// (RULE10) first byte with MSB set is a command byte stored as register pointer
// (RULE11) host should write threshold pairs with one word write
// (RULE12) host should keep channel selection consistent with threshold values
// (RULE13) source bits 1:0 select green, red, blue or clear for comparison
// (RULE14) persistence: every cycle, single, 0.1 s or 1 s out of range
// (RULE15) compare once per completed integration using prescaled selected result
`timescale 1ns/10ps
module gpti_core #(
    parameter int QUAL_SHORT_CYCLES = gpti_pkg::QUAL_SHORT_CYCLES,
    parameter int QUAL_LONG_CYCLES  = gpti_pkg::QUAL_LONG_CYCLES
) (
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    input  wire gpti_pkg::gpti_byte_type   wr_byte,
    input  wire logic                      rd_req,
    output logic [7:0]                     rd_data,
    output logic                           rd_ack,
    input  wire gpti_pkg::gpti_counts_type adc_counts,
    input  wire logic                      adc_done,
    output logic [1:0]                     analog_gain,
    output gpti_pkg::gpti_counts_type      scaled_counts,
    output logic                           irq
);
    // ******************************************************************
    // register file
    // ******************************************************************
    logic [4:0]  pointer;
    logic [7:0]  irq_ctrl;
    logic [7:0]  irq_source;
    logic [7:0]  gain_and_divider_ctrl;
    logic [7:0]  low_threshold_lsb;
    logic [7:0]  low_threshold_msb;
    logic [7:0]  high_threshold_lsb;
    logic [7:0]  high_threshold_msb;
    logic        is_command;
    logic        data_wr;
    logic        irq_clear;

    assign is_command = wr_byte.valid && wr_byte.first && wr_byte.data[gpti_pkg::CMD_BIT];
    assign data_wr    = wr_byte.valid && !is_command;
    assign irq_clear  = is_command && wr_byte.data[gpti_pkg::CMD_CLEAR_BIT];

    // pointer: command byte loads it, data bytes and reads step it for word transfers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pointer <= 5'h00;
        end else if (is_command) begin
            pointer <= wr_byte.data[4:0]; // RULE10
        end else if (data_wr || rd_req) begin
            pointer <= pointer + 5'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_ctrl              <= gpti_pkg::RESET_BYTE;
            irq_source            <= gpti_pkg::RESET_BYTE;
            gain_and_divider_ctrl <= gpti_pkg::RESET_BYTE;
            low_threshold_lsb     <= gpti_pkg::RESET_BYTE; // RULE9
            low_threshold_msb     <= gpti_pkg::RESET_BYTE; // RULE9
            high_threshold_lsb    <= gpti_pkg::RESET_BYTE; // RULE9
            high_threshold_msb    <= gpti_pkg::RESET_BYTE; // RULE9
        end else if (data_wr) begin
            // reserved bits are masked so they always read zero
            unique case (pointer)
                gpti_pkg::ADDR_IRQ_CTRL: begin
                    irq_ctrl <= wr_byte.data & gpti_pkg::CTRL_WRITE_MASK;
                end
                gpti_pkg::ADDR_IRQ_SOURCE: begin
                    irq_source <= wr_byte.data & gpti_pkg::SOURCE_WRITE_MASK;
                end
                gpti_pkg::ADDR_GAIN_DIV: begin
                    gain_and_divider_ctrl <= wr_byte.data & gpti_pkg::GAIN_WRITE_MASK; // RULE4
                end
                gpti_pkg::ADDR_LOW_LSB: begin
                    low_threshold_lsb <= wr_byte.data; // RULE6
                end
                gpti_pkg::ADDR_LOW_MSB: begin
                    low_threshold_msb <= wr_byte.data; // RULE6
                end
                gpti_pkg::ADDR_HIGH_LSB: begin
                    high_threshold_lsb <= wr_byte.data; // RULE6
                end
                gpti_pkg::ADDR_HIGH_MSB: begin
                    high_threshold_msb <= wr_byte.data; // RULE6
                end
                default: begin
                end
            endcase
        end
    end

    // ******************************************************************
    // gain and prescaler
    // ******************************************************************
    logic [2:0]  div_sel;
    logic [15:0] raw_ch    [4];
    logic [15:0] scaled_ch [4];
    logic [15:0] shifted   [4];

    assign analog_gain = gain_and_divider_ctrl[gpti_pkg::GAIN_MSB:gpti_pkg::GAIN_LSB]; // RULE1 RULE2
    // the unused code falls back to divide by one rather than an undefined shift
    assign div_sel = (gain_and_divider_ctrl[gpti_pkg::DIV_MSB:gpti_pkg::DIV_LSB] == gpti_pkg::DIV_UNUSED)
                   ? 3'h0 : gain_and_divider_ctrl[gpti_pkg::DIV_MSB:gpti_pkg::DIV_LSB];

    assign raw_ch[0] = adc_counts.green;
    assign raw_ch[1] = adc_counts.red;
    assign raw_ch[2] = adc_counts.blue;
    assign raw_ch[3] = adc_counts.clear;

    for (genvar ch = 0; ch < 4; ch++) begin : g_chan
        assign shifted[ch] = raw_ch[ch] >> div_sel; // RULE3
        always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
                scaled_ch[ch] <= 16'h0000;
            end else if (adc_done) begin
                scaled_ch[ch] <= shifted[ch];
            end
        end
    end

    assign scaled_counts.green = scaled_ch[0];
    assign scaled_counts.red   = scaled_ch[1];
    assign scaled_counts.blue  = scaled_ch[2];
    assign scaled_counts.clear = scaled_ch[3];

    // ******************************************************************
    // threshold compare and persistence
    // ******************************************************************
    logic [15:0] low_thr;
    logic [15:0] high_thr;
    logic [15:0] selected;
    logic        out_of_range;
    logic [2:0]  qualify;
    logic [31:0] out_cycles;
    logic        fire;

    assign low_thr      = {low_threshold_msb, low_threshold_lsb};   // RULE5
    assign high_thr     = {high_threshold_msb, high_threshold_lsb}; // RULE5
    assign selected     = shifted[irq_source[1:0]];                 // RULE13 RULE15
    assign out_of_range = (selected <= low_thr) || (selected > high_thr); // RULE7 RULE8
    assign qualify      = irq_ctrl[2:0];

    // counts cycles since the first of an unbroken run of out-of-range results
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            out_cycles <= 32'h00000000;
        end else if (adc_done && !out_of_range) begin
            out_cycles <= 32'h00000000;
        end else if (adc_done || out_cycles != 32'h00000000) begin
            if (out_cycles != 32'hFFFFFFFF) begin
                out_cycles <= out_cycles + 32'h00000001;
            end
        end
    end

    always_comb begin
        fire = 1'b0;
        if (adc_done) begin // RULE15
            unique case (qualify)
                gpti_pkg::QUAL_EVERY: begin
                    fire = 1'b1; // RULE14
                end
                gpti_pkg::QUAL_SHORT: begin
                    fire = out_of_range && (out_cycles >= 32'(QUAL_SHORT_CYCLES)); // RULE14
                end
                gpti_pkg::QUAL_LONG: begin
                    fire = out_of_range && (out_cycles >= 32'(QUAL_LONG_CYCLES)); // RULE14
                end
                default: begin
                    fire = out_of_range; // RULE14
                end
            endcase
        end
    end

    // level interrupt held until the host clears it; a new event beats the clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else if (fire) begin
            irq <= 1'b1; // RULE7 RULE8
        end else if (irq_clear) begin
            irq <= 1'b0;
        end
    end

    // ******************************************************************
    // read path
    // ******************************************************************
    logic [7:0] next_rd_data;
    logic [2:0] data_idx;

    assign data_idx = pointer[2:0];

    always_comb begin
        next_rd_data = gpti_pkg::RESET_BYTE;
        unique case (pointer)
            gpti_pkg::ADDR_IRQ_CTRL:   next_rd_data = irq_ctrl;
            gpti_pkg::ADDR_IRQ_SOURCE: next_rd_data = irq_source;
            gpti_pkg::ADDR_GAIN_DIV:   next_rd_data = gain_and_divider_ctrl;
            gpti_pkg::ADDR_LOW_LSB:    next_rd_data = low_threshold_lsb;
            gpti_pkg::ADDR_LOW_MSB:    next_rd_data = low_threshold_msb;
            gpti_pkg::ADDR_HIGH_LSB:   next_rd_data = high_threshold_lsb;
            gpti_pkg::ADDR_HIGH_MSB:   next_rd_data = high_threshold_msb;
            default: begin
                if (pointer >= gpti_pkg::ADDR_DATA_BASE && pointer <= gpti_pkg::ADDR_DATA_LAST) begin
                    next_rd_data = data_idx[0] ? scaled_ch[data_idx[2:1]][15:8]
                                               : scaled_ch[data_idx[2:1]][7:0];
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_data <= gpti_pkg::RESET_BYTE;
            rd_ack  <= 1'b0;
        end else begin
            rd_ack <= rd_req;
            if (rd_req) begin
                rd_data <= next_rd_data;
            end
        end
    end
endmodule

//--- logic/gpti_pkg.sv
// package of constants and types for the gain, prescale and threshold interrupt block
package gpti_pkg;
    // ******************************************************************
    // register offsets
    // ******************************************************************
    localparam logic [4:0] ADDR_IRQ_CTRL   = 5'h02;
    localparam logic [4:0] ADDR_IRQ_SOURCE = 5'h03;
    localparam logic [4:0] ADDR_GAIN_DIV   = 5'h07;
    localparam logic [4:0] ADDR_LOW_LSB    = 5'h08;
    localparam logic [4:0] ADDR_LOW_MSB    = 5'h09;
    localparam logic [4:0] ADDR_HIGH_LSB   = 5'h0A;
    localparam logic [4:0] ADDR_HIGH_MSB   = 5'h0B;
    localparam logic [4:0] ADDR_DATA_BASE  = 5'h10;
    localparam logic [4:0] ADDR_DATA_LAST  = 5'h17;

    // ******************************************************************
    // field positions and reset values
    // ******************************************************************
    localparam int CMD_BIT          = 7;
    localparam int CMD_CLEAR_BIT    = 6;
    localparam int GAIN_LSB         = 4;
    localparam int GAIN_MSB         = 5;
    localparam int DIV_LSB          = 0;
    localparam int DIV_MSB          = 2;
    localparam logic [2:0] DIV_UNUSED = 3'h7;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] GAIN_WRITE_MASK = 8'h37;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h07;
    localparam logic [7:0] SOURCE_WRITE_MASK = 8'h03;

    // persistence codes
    localparam logic [2:0] QUAL_EVERY  = 3'h0;
    localparam logic [2:0] QUAL_SINGLE = 3'h1;
    localparam logic [2:0] QUAL_SHORT  = 3'h2;
    localparam logic [2:0] QUAL_LONG   = 3'h3;

    // ******************************************************************
    // timing
    // ******************************************************************
    localparam int CLK_HZ        = 25_000_000;
    localparam int QUAL_SHORT_MS = 100;
    localparam int QUAL_LONG_MS  = 1000;
    localparam int QUAL_SHORT_CYCLES = (CLK_HZ / 1000) * QUAL_SHORT_MS;
    localparam int QUAL_LONG_CYCLES  = (CLK_HZ / 1000) * QUAL_LONG_MS;

    // one byte from the two-wire front end after address match
    typedef struct packed {
        logic       valid;
        logic       first;
        logic [7:0] data;
    } gpti_byte_type;

    typedef struct packed {
        logic [15:0] green;
        logic [15:0] red;
        logic [15:0] blue;
        logic [15:0] clear;
    } gpti_counts_type;
endpackage

//--- tb/gain_prescale_threshold_irq_test.sv
// self-checking bench for the gain, prescale and threshold interrupt core
`timescale 1ns/10ps
module gain_prescale_threshold_irq_test;
    logic                      ref_clk;
    logic                      rst_n;
    gpti_pkg::gpti_byte_type   wr_byte;
    logic                      rd_req;
    logic [7:0]                rd_data;
    logic                      rd_ack;
    gpti_pkg::gpti_counts_type adc_counts;
    logic                      adc_done;
    logic [1:0]                analog_gain;
    gpti_pkg::gpti_counts_type scaled_counts;
    logic                      irq;
    int                        n_fail;
    int                        tests_run;
    gpti_core #(.QUAL_SHORT_CYCLES(20), .QUAL_LONG_CYCLES(100)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .wr_byte(wr_byte), .rd_req(rd_req), .rd_data(rd_data), .rd_ack(rd_ack), .adc_counts(adc_counts),
        .adc_done(adc_done), .analog_gain(analog_gain), .scaled_counts(scaled_counts), .irq(irq));
    gpti_host_model host (.ref_clk(ref_clk), .wr_byte(wr_byte), .rd_req(rd_req), .rd_data(rd_data),
        .rd_ack(rd_ack));
    initial begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] v;
        logic       ack;
        host.send(1'h1, {3'h4, a});
        host.fetch(v, ack);
        chk({ack, 7'h00, v}, {8'h80, e});
    endtask
    task automatic adc(input gpti_pkg::gpti_counts_type c);
        @(posedge ref_clk) #1 adc_counts = c;
        adc_done = 1'h1;
        @(posedge ref_clk) #1 adc_done = 1'h0;
        adc_counts = ~c;
    endtask
    task automatic test_regs();
        logic [7:0] v;
        logic       ack;
        for (int a = 7; a < 12; a++) begin
            rdchk(a[4:0], 8'h00);
        end
        host.word(5'h08, 16'h1234);
        host.word(5'h0A, 16'hABCD);
        rdchk(5'h08, 8'h34);
        rdchk(5'h09, 8'h12);
        rdchk(5'h0B, 8'hAB);
        // a second command byte in place of data must not reach the threshold
        host.send(1'h1, 8'h88);
        host.send(1'h1, 8'h8B);
        host.fetch(v, ack);
        chk({ack, 7'h00, v}, 16'h80AB);
        rdchk(5'h08, 8'h34);
        // a lone byte with its top bit set only moves the pointer
        rdchk(5'h0A, 8'hCD);
    endtask
    task automatic test_gain_div();
        gpti_pkg::gpti_counts_type c;
        int s;
        c = {16'hFFFF, 16'h8000, 16'h1234, 16'h0F0F};
        for (int d = 0; d < 8; d++) begin
            host.gain_write({2'h0, d[1:0], 1'h0, d[2:0]});
            chk({14'h0, analog_gain}, {14'h0, d[1:0]});
            adc(c);
            s = (d == 7) ? 0 : d;
            chk(scaled_counts.green, c.green >> s);
            chk(scaled_counts.red, c.red >> s);
            chk(scaled_counts.blue, c.blue >> s);
            chk(scaled_counts.clear, c.clear >> s);
        end
        host.gain_write(8'h00);
        adc(c);
        rdchk(5'h10, 8'hFF);
        rdchk(5'h13, 8'h80);
        rdchk(5'h14, 8'h34);
        rdchk(5'h17, 8'h0F);
    endtask
    task automatic test_irq();
        gpti_pkg::gpti_counts_type c;
        logic [15:0] vals [4] = '{16'h0100, 16'h0101, 16'h0200, 16'h0201};
        host.word(5'h08, 16'h0100);
        host.word(5'h0A, 16'h0200);
        for (int src = 0; src < 4; src++) begin
            host.word(5'h02, {6'h00, src[1:0], 8'h01});
            for (int i = 0; i < 4; i++) begin
                c = {4{16'h0150}};
                c[(3 - src) * 16 +: 16] = vals[i];
                host.send(1'h1, 8'hC0);
                adc(c);
                chk({15'h0, irq}, {15'h0, i == 0 || i == 3});
            end
        end
    endtask
    task automatic test_irq_qualify_rate();
        host.word(5'h02, 16'h0300);
        host.send(1'h1, 8'hC0);
        adc({4{16'h0150}});
        chk({15'h0, irq}, 16'h0001);
        host.word(5'h02, 16'h0302);
        host.send(1'h1, 8'hC0);
        adc('0);
        chk({15'h0, irq}, 16'h0000);
        repeat (25) @(posedge ref_clk);
        adc('0);
        chk({15'h0, irq}, 16'h0001);
        // long run: an in-range result restarts the count first
        host.word(5'h02, 16'h0303);
        adc({4{16'h0150}});
        host.send(1'h1, 8'hC0);
        adc('0);
        chk({15'h0, irq}, 16'h0000);
        repeat (50) @(posedge ref_clk);
        adc('0);
        chk({15'h0, irq}, 16'h0000);
        repeat (60) @(posedge ref_clk);
        adc('0);
        chk({15'h0, irq}, 16'h0001);
        host.word(5'h02, 16'h0304);
        host.send(1'h1, 8'hC0);
        adc('0);
        chk({15'h0, irq}, 16'h0001);
    endtask
    task automatic test_reset();
        @(posedge ref_clk) #1 rst_n = 1'h0;
        repeat (2) @(posedge ref_clk);
        #1 rst_n = 1'h1;
        chk({15'h0, irq}, 16'h0000);
        chk(scaled_counts.clear, 16'h0000);
        rdchk(5'h08, 8'h00);
        rdchk(5'h0B, 8'h00);
        rdchk(5'h07, 8'h00);
    endtask
    initial begin
        n_fail = 0;
        tests_run = 0;
        rst_n = 1'h0;
        adc_done = 1'h0;
        adc_counts = '0;
        repeat (6) @(posedge ref_clk);
        #1 rst_n = 1'h1;
        test_regs();
        test_gain_div();
        test_irq();
        test_irq_qualify_rate();
        test_reset();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        print_verdict();
    end
endmodule

//--- tb/gpti_core_checker.sv
// concurrent checks on the ports of the gain, prescale and threshold interrupt core
`timescale 1ns/10ps
module gpti_core_checker (
    input wire logic                      ref_clk,
    input wire logic                      rst_n,
    input wire gpti_pkg::gpti_byte_type   wr_byte,
    input wire logic                      rd_req,
    input wire logic [7:0]                rd_data,
    input wire logic                      rd_ack,
    input wire gpti_pkg::gpti_counts_type adc_counts,
    input wire logic                      adc_done,
    input wire logic [1:0]                analog_gain,
    input wire gpti_pkg::gpti_counts_type scaled_counts,
    input wire logic                      irq
);
    // ****************************************
    // shadow of pointer, control, source, gain and threshold registers
    // ****************************************
    logic [4:0]  ptr;
    logic [7:0]  gain;
    logic [7:0]  ctl;
    logic [7:0]  src;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] pick;
    logic        outr;
    logic [2:0]  sh;
    logic        clr;
    assign sh   = (gain[2:0] == 3'h7) ? 3'h0 : gain[2:0];
    assign clr  = wr_byte.valid && wr_byte.first && (wr_byte.data[7:6] == 2'h3);
    assign pick = ((src[1:0] == 2'h0) ? adc_counts.green : (src[1:0] == 2'h1) ? adc_counts.red
                 : (src[1:0] == 2'h2) ? adc_counts.blue : adc_counts.clear) >> sh;
    assign outr = (pick <= lo) || (pick > hi);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ptr  <= 5'h00;
            gain <= 8'h00;
            ctl  <= 8'h00;
            src  <= 8'h00;
            lo   <= 16'h0000;
            hi   <= 16'h0000;
        end else if (wr_byte.valid && wr_byte.first && wr_byte.data[7]) begin
            ptr <= wr_byte.data[4:0];
        end else if (wr_byte.valid) begin
            ptr <= ptr + 5'h01;
            if (ptr == 5'h02) begin
                ctl <= wr_byte.data & 8'h07;
            end
            if (ptr == 5'h03) begin
                src <= wr_byte.data & 8'h03;
            end
            if (ptr == 5'h07) begin
                gain <= wr_byte.data & 8'h37;
            end
            if (ptr == 5'h08) begin
                lo[7:0] <= wr_byte.data;
            end
            if (ptr == 5'h09) begin
                lo[15:8] <= wr_byte.data;
            end
            if (ptr == 5'h0A) begin
                hi[7:0] <= wr_byte.data;
            end
            if (ptr == 5'h0B) begin
                hi[15:8] <= wr_byte.data;
            end
        end else if (rd_req) begin
            ptr <= ptr + 5'h01;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_ack_follows_req: assert property (rd_req |=> rd_ack) else $error("no read ack");
    a_ack_only_req: assert property (!rd_req |=> !rd_ack) else $error("stray read ack");
    a_data_stands: assert property (!rd_req |=> $stable(rd_data)) else $error("read data moved");
    a_gain_common: assert property (analog_gain == gain[5:4]) else $error("gain wrong");
    a_scale_shift: assert property (adc_done |=> scaled_counts.green == ($past(adc_counts.green) >> $past(sh))
        && scaled_counts.clear == ($past(adc_counts.clear) >> $past(sh))) else $error("bad scale");
    a_scale_hold: assert property (!adc_done |=> $stable(scaled_counts)) else $error("counts moved");
    a_irq_cause: assert property ($rose(irq) |-> $past(adc_done)) else $error("irq without result");
    a_irq_clear: assert property (clr && !adc_done |=> !irq) else $error("irq not cleared");
    a_irq_fires: assert property (adc_done && (ctl[2:0] == 3'h1) && outr |=> irq) else $error("irq not raised");
    a_irq_quiet: assert property (adc_done && (ctl[2:0] == 3'h1) && !outr && !irq |=> !irq) else $error("irq in range");
    a_irq_holds: assert property (irq && !clr |=> irq) else $error("irq dropped");
endmodule
bind gpti_core gpti_core_checker chk (.ref_clk(ref_clk), .rst_n(rst_n), .wr_byte(wr_byte), .rd_req(rd_req),
    .rd_data(rd_data), .rd_ack(rd_ack), .adc_counts(adc_counts), .adc_done(adc_done),
    .analog_gain(analog_gain), .scaled_counts(scaled_counts), .irq(irq));

//--- tb/gpti_host_model.sv
// host model that sends and fetches bytes over the register port
`timescale 1ns/10ps
module gpti_host_model (
    input  wire logic              ref_clk,
    output gpti_pkg::gpti_byte_type wr_byte,
    output logic                   rd_req,
    input  wire logic [7:0]        rd_data,
    input  wire logic              rd_ack
);
    initial begin
        wr_byte = '0;
        rd_req = 1'h0;
    end
    task automatic send(input logic first, input logic [7:0] d);
        @(posedge ref_clk) #1 wr_byte = {1'h1, first, d};
        // released data must not keep showing the last byte
        @(posedge ref_clk) #1 wr_byte = {2'h0, ~d};
    endtask
    task automatic word(input logic [4:0] a, input logic [15:0] v);
        send(1'h1, {3'h4, a});
        send(1'h0, v[7:0]);
        send(1'h0, v[15:8]);
    endtask
    task automatic gain_write(input logic [7:0] v);
        send(1'h1, 8'h87);
        send(1'h0, v & 8'h37);
    endtask
    task automatic fetch(output logic [7:0] d, output logic ack);
        @(posedge ref_clk) #1 rd_req = 1'h1;
        @(posedge ref_clk) #1 rd_req = 1'h0;
        d = rd_data;
        ack = rd_ack;
    endtask
endmodule
